// *** hw/fpmc_defines.svh ***
// Purpose: Constants of the front-panel mode controller
// Assumes: Included by bare name from every design file but the package
// Notes:   Definitions only
`ifndef FPMC_DEFINES_SVH
`define FPMC_DEFINES_SVH

// Bus address range and defaults
`define FPMC_ADDR_W         5
`define FPMC_ADDR_MIN       5'h00
`define FPMC_ADDR_MAX       5'h1E
`define FPMC_ADDR_STEP      5'h01
`define FPMC_OWN_ADDR_DFLT  5'h10

// Keypad entry accumulator
`define FPMC_ENTRY_W        7
`define FPMC_ENTRY_ZERO     7'h00
`define FPMC_ENTRY_SAT      7'h0B
`define FPMC_ENTRY_OVF      7'h7F
`define FPMC_DEC_BASE       7'h0A

// Enables after power-up
`define FPMC_REMOTE_EN_DFLT 1'h1
`define FPMC_MDC_EN_DFLT    1'h0

// Brightness
`define FPMC_BRIGHT_W       2
`define FPMC_BRIGHT_FULL    2'h3
`define FPMC_BRIGHT_STEP    2'h1

// Scan rate
`define FPMC_RATE_W         3
`define FPMC_RATE_INIT      3'h3
`define FPMC_RATE_MIN       3'h0
`define FPMC_RATE_MAX       3'h7
`define FPMC_RATE_STEP      3'h1

`endif

// *** hw/fpmc_pkg.sv ***
// Purpose: Types shared by the front-panel mode controller
// Assumes: Nothing
// Notes:   Enumerations carry no explicit codes
package fpmc_pkg;
    typedef enum logic [2:0] {md_tune, md_scan, md_bright, md_bus, md_reset} fpmc_mode_t;
    typedef enum logic [1:0] {rs_iface, rs_temp, rs_perm, rs_full} fpmc_rsel_t;
    typedef enum logic [1:0] {sc_idle, sc_to_stop, sc_to_start, sc_pause} fpmc_scan_t;
    typedef enum logic {it_remote, it_mdc} fpmc_item_t;
endpackage

// *** hw/fpmc_addr_if.sv ***
// Purpose: Link between the mode controller and one bus address store
// Assumes: Key strobes are one-cycle pulses
// Notes:   ctl drives the strobes, store answers
`include "fpmc_defines.svh"
interface fpmc_addr_if;
    logic                     load;
    logic [`FPMC_ADDR_W-1:0]  load_val;
    logic                     en;
    logic                     digit_valid;
    logic [3:0]               digit;
    logic                     enter;
    logic                     clear;
    logic                     up;
    logic                     dn;
    logic [`FPMC_ADDR_W-1:0]  addr;
    logic                     commit;
    logic                     err;
    modport ctl   (output load, load_val, en, digit_valid, digit, enter, clear, up, dn,
                   input addr, commit, err);
    modport store (input load, load_val, en, digit_valid, digit, enter, clear, up, dn,
                   output addr, commit, err);
endinterface

// *** hw/fpmc_addr_reg.sv ***
// Purpose: One bus address with keypad entry and knob stepping
// Assumes: Strobes are single-cycle pulses
// Notes:   Knob stepping saturates at the range ends
`include "fpmc_defines.svh"
module fpmc_addr_reg (
    // Clock and reset
    input  wire logic     core_clk_i,
    input  wire logic     rst_n_i,
    // Controller side
    fpmc_addr_if.store    a
);
    logic [`FPMC_ENTRY_W-1:0] entry;
    logic                     busy;
    logic                     legal;

    assign legal = entry <= {2'h0, `FPMC_ADDR_MAX};

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            entry <= `FPMC_ENTRY_ZERO;
            busy  <= 1'b0;
        end else if (a.load || !a.en || a.enter || a.clear) begin
            entry <= `FPMC_ENTRY_ZERO;
            busy  <= 1'b0;
        end else if (a.digit_valid) begin
            busy <= 1'b1;
            if (!busy)
                entry <= {3'h0, a.digit};
            else if (entry > `FPMC_ENTRY_SAT)
                entry <= `FPMC_ENTRY_OVF;
            else
                entry <= `FPMC_ENTRY_W'(entry * `FPMC_DEC_BASE + {3'h0, a.digit});
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            a.addr   <= `FPMC_OWN_ADDR_DFLT;
            a.commit <= 1'b0;
            a.err    <= 1'b0;
        end else begin
            a.commit <= 1'b0;
            a.err    <= 1'b0;
            if (a.load) begin
                a.addr <= (a.load_val > `FPMC_ADDR_MAX) ? `FPMC_ADDR_MAX : a.load_val;
            end else if (a.en && busy && a.enter) begin
                if (legal) begin
                    a.addr   <= entry[`FPMC_ADDR_W-1:0];
                    a.commit <= 1'b1;
                end else begin
                    a.err <= 1'b1;
                end
            end else if (a.en && !busy && a.up && a.addr < `FPMC_ADDR_MAX) begin
                a.addr   <= a.addr + `FPMC_ADDR_STEP;
                a.commit <= 1'b1;
            end else if (a.en && !busy && a.dn && a.addr > `FPMC_ADDR_MIN) begin
                a.addr   <= a.addr - `FPMC_ADDR_STEP;
                a.commit <= 1'b1;
            end
        end
    end
endmodule

// *** hw/fpmc_scan.sv ***
// Purpose: Scan sequencing from the select and step keys
// Assumes: Keys arrive already gated for scan mode
// Notes:   Rate is a small code read by the tuner
`include "fpmc_defines.svh"
module fpmc_scan (
    // Clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     clr_i,
    // Keys
    input  wire logic                     left_i,
    input  wire logic                     right_i,
    input  wire logic                     step_i,
    // State
    output fpmc_pkg::fpmc_scan_t          state_o,
    output logic [`FPMC_RATE_W-1:0]       rate_o
);
    logic last_stop;
    logic faster;
    logic slower;

    assign faster = (state_o == fpmc_pkg::sc_to_stop  && left_i) ||
                    (state_o == fpmc_pkg::sc_to_start && right_i);
    assign slower = (state_o == fpmc_pkg::sc_to_stop  && right_i) ||
                    (state_o == fpmc_pkg::sc_to_start && left_i);

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_o   <= fpmc_pkg::sc_idle;
            last_stop <= 1'b1;
        end else if (clr_i) begin
            state_o   <= fpmc_pkg::sc_idle;
            last_stop <= 1'b1;
        end else begin
            case (state_o)
                fpmc_pkg::sc_idle, fpmc_pkg::sc_pause: begin
                    if (left_i) begin
                        state_o   <= fpmc_pkg::sc_to_stop;
                        last_stop <= 1'b1;
                    end else if (right_i) begin
                        state_o   <= fpmc_pkg::sc_to_start;
                        last_stop <= 1'b0;
                    end else if (step_i && state_o == fpmc_pkg::sc_pause) begin
                        state_o <= last_stop ? fpmc_pkg::sc_to_stop : fpmc_pkg::sc_to_start;
                    end
                end
                fpmc_pkg::sc_to_stop, fpmc_pkg::sc_to_start: begin
                    if (step_i)
                        state_o <= fpmc_pkg::sc_pause;
                end
                default: state_o <= fpmc_pkg::sc_idle;
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            rate_o <= `FPMC_RATE_INIT;
        else if (clr_i)
            rate_o <= `FPMC_RATE_INIT;
        else if (faster && rate_o < `FPMC_RATE_MAX)
            rate_o <= rate_o + `FPMC_RATE_STEP;
        else if (slower && rate_o > `FPMC_RATE_MIN)
            rate_o <= rate_o - `FPMC_RATE_STEP;
    end
endmodule

// *** hw/fpmc_front_panel.sv ***
// Purpose: Front-panel mode control: local, remote and downconverter roles
// Assumes: Keys and host remote and local requests are one-cycle pulses synchronous to core_clk_i; lockout is a level
// Notes:   Addresses are loaded on the first edge after rst_n_i or a restart
`include "fpmc_defines.svh"

module fpmc_front_panel (
    // Clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    // Power-up sources
    input  wire logic [`FPMC_ADDR_W-1:0]  dip_addr_i,
    input  wire logic [`FPMC_ADDR_W-1:0]  nv_mdc_addr_i,
    input  wire logic                     board_reset_i,
    // Panel keys
    input  wire logic                     alt_key_i,
    input  wire logic                     enter_key_i,
    input  wire logic                     clear_key_i,
    input  wire logic                     bright_key_i,
    input  wire logic                     scan_key_i,
    input  wire logic                     tune_key_i,
    input  wire logic                     digit_valid_i,
    input  wire logic [3:0]               digit_i,
    input  wire logic                     sel_left_i,
    input  wire logic                     sel_center_i,
    input  wire logic                     sel_right_i,
    input  wire logic                     step_key_i,
    input  wire logic                     knob_up_i,
    input  wire logic                     knob_dn_i,
    // Host requests
    input  wire logic                     host_remote_i,
    input  wire logic                     host_local_i,
    input  wire logic                     host_llo_i,
    // Bus roles
    output logic                          remote_o,
    output logic                          remote_en_o,
    output logic                          mdc_en_o,
    output logic                          bus_ctrl_hold_o,
    output logic                          bus_ctrl_reinit_o,
    output logic                          mdc_release_o,
    // Addresses and storage
    output logic [`FPMC_ADDR_W-1:0]       own_addr_o,
    output logic [`FPMC_ADDR_W-1:0]       mdc_addr_o,
    output logic                          nv_wr_o,
    output logic [`FPMC_ADDR_W-1:0]       nv_wr_data_o,
    output logic                          entry_err_o,
    // Panel indication
    output logic                          alt_lamp_o,
    output logic                          bus_lamp_o,
    output fpmc_pkg::fpmc_mode_t          mode_o,
    output fpmc_pkg::fpmc_item_t          bus_item_o,
    output fpmc_pkg::fpmc_rsel_t          reset_sel_o,
    output logic [`FPMC_BRIGHT_W-1:0]     bright_o,
    // Functions gated by remote
    output logic                          beat_osc_en_o,
    output logic                          zx_axis_en_o,
    output logic                          audible_en_o,
    // Resets issued
    output logic                          mem_rst_temp_o,
    output logic                          mem_rst_perm_o,
    output logic                          sys_restart_o,
    // Scan
    output fpmc_pkg::fpmc_scan_t          scan_state_o,
    output logic [`FPMC_RATE_W-1:0]       scan_rate_o
);
    fpmc_addr_if own_if ();
    fpmc_addr_if mdc_if ();

    logic init_done;
    logic alt_pend;
    logic ok_key;
    logic alt_h;
    logic alt_c;
    logic alt_m;
    logic in_bus;
    logic in_rst;
    logic in_bright;
    logic in_scan;
    logic rst_fire;
    logic iface_rst;
    logic restart;
    logic ret_local;
    logic center_rem;
    logic center_mdc;

    assign ok_key    = !remote_o;
    assign alt_h     = alt_pend && enter_key_i && ok_key;
    assign alt_c     = alt_pend && clear_key_i;
    assign alt_m     = alt_pend && bright_key_i && ok_key;
    assign in_bus    = (mode_o == fpmc_pkg::md_bus) && ok_key && !alt_pend;
    assign in_rst    = (mode_o == fpmc_pkg::md_reset) && ok_key && !alt_pend;
    assign in_bright = (mode_o == fpmc_pkg::md_bright) && ok_key && !alt_pend;
    assign in_scan   = (mode_o == fpmc_pkg::md_scan) && ok_key && !alt_pend;

    assign rst_fire  = in_rst && enter_key_i;
    assign iface_rst = rst_fire && reset_sel_o == fpmc_pkg::rs_iface;
    assign restart   = init_done && (board_reset_i ||
                       (rst_fire && reset_sel_o == fpmc_pkg::rs_full));
    assign ret_local = remote_o && alt_c && !host_llo_i;

    assign center_rem = in_bus && sel_center_i && bus_item_o == fpmc_pkg::it_remote;
    assign center_mdc = in_bus && sel_center_i && bus_item_o == fpmc_pkg::it_mdc;

    // Power-up load marker, reopened by a restart
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            init_done <= 1'b0;
        else
            init_done <= !restart;
    end

    assign own_if.load        = !init_done;
    assign own_if.load_val    = dip_addr_i;
    assign own_if.en          = in_bus && bus_item_o == fpmc_pkg::it_remote && remote_en_o;
    assign own_if.digit_valid = digit_valid_i;
    assign own_if.digit       = digit_i;
    assign own_if.enter       = enter_key_i;
    assign own_if.clear       = clear_key_i;
    assign own_if.up          = knob_up_i;
    assign own_if.dn          = knob_dn_i;

    assign mdc_if.load        = !init_done;
    assign mdc_if.load_val    = nv_mdc_addr_i;
    assign mdc_if.en          = in_bus && bus_item_o == fpmc_pkg::it_mdc && mdc_en_o;
    assign mdc_if.digit_valid = digit_valid_i;
    assign mdc_if.digit       = digit_i;
    assign mdc_if.enter       = enter_key_i;
    assign mdc_if.clear       = clear_key_i;
    assign mdc_if.up          = knob_up_i;
    assign mdc_if.dn          = knob_dn_i;

    fpmc_addr_reg u_own_addr (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .a          (own_if.store)
    );

    fpmc_addr_reg u_mdc_addr (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .a          (mdc_if.store)
    );

    assign own_addr_o = own_if.addr;
    assign mdc_addr_o = mdc_if.addr;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nv_wr_o      <= 1'b0;
            nv_wr_data_o <= `FPMC_ADDR_MIN;
            entry_err_o  <= 1'b0;
        end else begin
            nv_wr_o      <= mdc_if.commit;
            nv_wr_data_o <= mdc_if.addr;
            entry_err_o  <= own_if.err || mdc_if.err;
        end
    end

    // Alternate key pending
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            alt_pend <= 1'b0;
        else if (restart || alt_h || alt_c || alt_m)
            alt_pend <= 1'b0;
        else if (alt_key_i)
            alt_pend <= !alt_pend;
    end

    // Panel mode
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            mode_o <= fpmc_pkg::md_tune;
        else if (restart || remote_o || rst_fire || (tune_key_i && ok_key))
            mode_o <= fpmc_pkg::md_tune;
        else if (alt_h)
            mode_o <= fpmc_pkg::md_bus;
        else if (alt_c)
            mode_o <= fpmc_pkg::md_reset;
        else if (alt_m)
            mode_o <= fpmc_pkg::md_bright;
        else if (scan_key_i && ok_key && !alt_pend)
            mode_o <= fpmc_pkg::md_scan;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            remote_en_o <= `FPMC_REMOTE_EN_DFLT;
            mdc_en_o    <= `FPMC_MDC_EN_DFLT;
        end else if (restart) begin
            remote_en_o <= `FPMC_REMOTE_EN_DFLT;
            mdc_en_o    <= `FPMC_MDC_EN_DFLT;
        end else if (center_rem) begin
            remote_en_o <= !remote_en_o;
            if (!remote_en_o)
                mdc_en_o <= 1'b0;
        end else if (center_mdc) begin
            mdc_en_o <= !mdc_en_o;
            if (!mdc_en_o)
                remote_en_o <= 1'b0;
        end
    end

    // Remote state
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            remote_o <= 1'b0;
        else if (restart || ret_local || host_local_i || !remote_en_o)
            remote_o <= 1'b0;
        else if (host_remote_i && !mdc_en_o)
            remote_o <= 1'b1;
    end

    // Bus controller handling
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_ctrl_hold_o   <= 1'b0;
            bus_ctrl_reinit_o <= 1'b0;
            mdc_release_o     <= 1'b0;
        end else begin
            bus_ctrl_hold_o   <= !remote_en_o && !mdc_en_o;
            bus_ctrl_reinit_o <= iface_rst;
            mdc_release_o     <= (center_mdc && mdc_en_o) || (iface_rst && mdc_en_o);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            bus_item_o <= fpmc_pkg::it_remote;
        else if (restart)
            bus_item_o <= fpmc_pkg::it_remote;
        else if (in_bus && (sel_left_i || sel_right_i))
            bus_item_o <= (bus_item_o == fpmc_pkg::it_remote) ? fpmc_pkg::it_mdc
                                                             : fpmc_pkg::it_remote;
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            reset_sel_o <= fpmc_pkg::rs_iface;
        else if (restart)
            reset_sel_o <= fpmc_pkg::rs_iface;
        else if (in_rst && sel_right_i)
            reset_sel_o <= fpmc_pkg::fpmc_rsel_t'(reset_sel_o + 2'h1);
        else if (in_rst && sel_left_i)
            reset_sel_o <= fpmc_pkg::fpmc_rsel_t'(reset_sel_o - 2'h1);
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_rst_temp_o <= 1'b0;
            mem_rst_perm_o <= 1'b0;
            sys_restart_o  <= 1'b0;
        end else begin
            mem_rst_temp_o <= rst_fire && reset_sel_o == fpmc_pkg::rs_temp;
            mem_rst_perm_o <= rst_fire && reset_sel_o == fpmc_pkg::rs_perm;
            sys_restart_o  <= restart;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            bright_o <= `FPMC_BRIGHT_FULL;
        else if (restart || (in_bright && step_key_i))
            bright_o <= `FPMC_BRIGHT_FULL;
        else if (in_bright && sel_left_i)
            bright_o <= bright_o - `FPMC_BRIGHT_STEP;
        else if (in_bright && sel_right_i)
            bright_o <= bright_o + `FPMC_BRIGHT_STEP;
    end

    // Lamps and remote-disabled functions
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            alt_lamp_o    <= 1'b0;
            bus_lamp_o    <= 1'b0;
            beat_osc_en_o <= 1'b1;
            zx_axis_en_o  <= 1'b1;
            audible_en_o  <= 1'b1;
        end else begin
            alt_lamp_o    <= alt_pend;
            bus_lamp_o    <= mode_o == fpmc_pkg::md_bus;
            beat_osc_en_o <= !remote_o;
            zx_axis_en_o  <= !remote_o;
            audible_en_o  <= !remote_o;
        end
    end

    fpmc_scan u_scan (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .clr_i      (restart || remote_o),
        .left_i     (in_scan && sel_left_i),
        .right_i    (in_scan && sel_right_i),
        .step_i     (in_scan && step_key_i),
        .state_o    (scan_state_o),
        .rate_o     (scan_rate_o)
    );
endmodule

// *** verif/fpmc_properties.sv ***
// Purpose: Port-level properties of the front-panel mode controller
// Assumes: Bound to fpmc_front_panel, one clock domain
// Notes:   Strobe timing is checked here, values in the bench
`include "fpmc_defines.svh"
module fpmc_properties (
    // Clock and reset
    input  wire logic                     core_clk_i,
    input  wire logic                     rst_n_i,
    // Inputs watched
    input  wire logic                     alt_key_i,
    input  wire logic                     clear_key_i,
    input  wire logic                     host_remote_i,
    input  wire logic                     host_llo_i,
    // Outputs watched
    input  wire logic                     remote_o,
    input  wire logic                     remote_en_o,
    input  wire logic                     mdc_en_o,
    input  wire logic                     bus_ctrl_hold_o,
    input  wire logic [`FPMC_ADDR_W-1:0]  own_addr_o,
    input  wire logic [`FPMC_ADDR_W-1:0]  mdc_addr_o,
    input  wire logic                     nv_wr_o,
    input  wire logic [`FPMC_ADDR_W-1:0]  nv_wr_data_o,
    input  wire fpmc_pkg::fpmc_mode_t     mode_o,
    input  wire logic                     beat_osc_en_o,
    input  wire logic                     alt_lamp_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    // Lamp lags pending by one cycle, so a quiet cycle makes it exact
    sequence s_alt_held;
        remote_o && !alt_key_i && !clear_key_i ##1 remote_o && alt_lamp_o;
    endsequence
    sequence s_ret;
        s_alt_held ##0 (clear_key_i && !host_llo_i);
    endsequence
    property p_excl; !(remote_o && mdc_en_o); endproperty
    property p_take; host_remote_i && remote_en_o && !mdc_en_o |=> remote_o; endproperty
    property p_beat; $rose(remote_o) |=> !beat_osc_en_o; endproperty
    property p_rng; own_addr_o <= `FPMC_ADDR_MAX && mdc_addr_o <= `FPMC_ADDR_MAX; endproperty
    property p_nv; nv_wr_o |-> nv_wr_data_o == $past(mdc_addr_o); endproperty
    property p_hold; (!remote_en_o && !mdc_en_o) [*2] |-> bus_ctrl_hold_o; endproperty
    property p_bus; remote_o && mode_o != fpmc_pkg::md_bus |=> mode_o != fpmc_pkg::md_bus;
    endproperty
    property p_ret; s_ret |=> !remote_o; endproperty
    a_excl: assert property (p_excl) else $error("both bus roles on");
    a_take: assert property (p_take) else $error("remote request lost");
    a_beat: assert property (p_beat) else $error("beat oscillator on in remote");
    a_rng: assert property (p_rng) else $error("address above range");
    a_nv: assert property (p_nv) else $error("stored address differs");
    a_hold: assert property (p_hold) else $error("bus controller not held");
    a_bus: assert property (p_bus) else $error("bus options opened in remote");
    a_ret: assert property (p_ret) else $error("no return to local");
endmodule

bind fpmc_front_panel fpmc_properties u_prop (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .alt_key_i(alt_key_i), .clear_key_i(clear_key_i), .host_remote_i(host_remote_i),
    .host_llo_i(host_llo_i), .remote_o(remote_o), .remote_en_o(remote_en_o),
    .mdc_en_o(mdc_en_o), .bus_ctrl_hold_o(bus_ctrl_hold_o), .own_addr_o(own_addr_o),
    .mdc_addr_o(mdc_addr_o), .nv_wr_o(nv_wr_o), .nv_wr_data_o(nv_wr_data_o),
    .mode_o(mode_o), .beat_osc_en_o(beat_osc_en_o), .alt_lamp_o(alt_lamp_o));

// *** verif/fpmc_host_model.sv ***
// Purpose: Host computer at the far end of the remote bus
// Assumes: Requests are one-cycle pulses launched at a rising edge
// Notes:   Lockout is a level held until changed
module fpmc_host_model (
    // Clock
    input  wire logic  core_clk_i,
    // Requests
    output logic       remote_o,
    output logic       local_o,
    output logic       llo_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        remote_o = 1'h0;
        local_o = 1'h0;
        llo_o = 1'h0;
    end
    task automatic ask(input logic rem);
        @(posedge core_clk_i);
        remote_o <= rem;
        local_o <= !rem;
        @(posedge core_clk_i);
        remote_o <= 1'h0;
        local_o <= 1'h0;
        repeat (2) @(negedge core_clk_i);
    endtask
    task automatic lock(input logic v);
        @(posedge core_clk_i);
        llo_o <= v;
    endtask
endmodule

// *** verif/fpmc_tb.sv ***
// Purpose: Self-checking bench for the front-panel mode controller
// Assumes: Keys are one-cycle pulses, three idle cycles between them
// Notes:   Strobes are counted, so a late or missing pulse shows
`include "fpmc_defines.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     clk;
    logic                     rst_n;
    logic [13:0]              k;
    logic [3:0]               dgt;
    logic [`FPMC_ADDR_W-1:0]  dip, nv, own, mdc, nvd, last_nv;
    logic                     rem, loc, llo, remote, ren, men, hold, nvw, eer, rel, blamp, beat;
    logic [1:0]               bright;
    logic                     mrt;
    fpmc_pkg::fpmc_mode_t     mode;
    int                       err_total, n_tests, n_err, n_nv, n_rel, n_mrt, a, b;
    fpmc_host_model hm (.core_clk_i(clk), .remote_o(rem), .local_o(loc), .llo_o(llo));
    fpmc_front_panel dut (.core_clk_i(clk), .rst_n_i(rst_n), .dip_addr_i(dip),
        .nv_mdc_addr_i(nv), .board_reset_i(k[13]), .alt_key_i(k[0]), .enter_key_i(k[1]),
        .clear_key_i(k[2]), .bright_key_i(k[3]), .scan_key_i(k[4]), .tune_key_i(k[5]),
        .digit_valid_i(k[6]), .digit_i(dgt), .sel_left_i(k[7]), .sel_center_i(k[8]),
        .sel_right_i(k[9]), .step_key_i(k[10]), .knob_up_i(k[11]), .knob_dn_i(k[12]),
        .host_remote_i(rem), .host_local_i(loc), .host_llo_i(llo), .remote_o(remote),
        .remote_en_o(ren), .mdc_en_o(men), .bus_ctrl_hold_o(hold), .bus_ctrl_reinit_o(),
        .mdc_release_o(rel), .own_addr_o(own), .mdc_addr_o(mdc), .nv_wr_o(nvw),
        .nv_wr_data_o(nvd), .entry_err_o(eer), .alt_lamp_o(), .bus_lamp_o(blamp),
        .mode_o(mode), .bus_item_o(), .reset_sel_o(), .bright_o(bright),
        .beat_osc_en_o(beat), .zx_axis_en_o(), .audible_en_o(), .mem_rst_temp_o(mrt),
        .mem_rst_perm_o(), .sys_restart_o(), .scan_state_o(), .scan_rate_o());
    initial begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        n_err += eer;
        n_nv += nvw;
        n_rel += rel;
        n_mrt += mrt;
        if (nvw === 1'h1) last_nv <= nvd;
    end
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic pr(int i, int d = 0);
        @(posedge clk);
        k[i] <= 1'h1;
        dgt <= d[3:0];
        @(posedge clk);
        k[i] <= 1'h0;
        // Strobes land a cycle after state, counters one edge later
        repeat (3) @(negedge clk);
    endtask
    task automatic ent(int v);
        pr(6, v / 10);
        pr(6, v % 10);
        pr(1);
    endtask
    task automatic rst;
        rst_n <= 1'h0;
        repeat (4) @(posedge clk);
        chk("own_in_reset", own, 8'h10);
        rst_n <= 1'h1;
        repeat (3) @(negedge clk);
    endtask
    task report_and_stop;
        $display("tests %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        err_total++;
        report_and_stop;
    end
    initial begin
        {k, dgt, rst_n, err_total, n_tests, n_err, n_nv, n_rel, n_mrt} = '0;
        a = $urandom(32'h5d77);
        dip = 5'($urandom % 31);
        nv = 5'($urandom % 31);
        rst;
        chk("own_load", own, 8'(dip));
        chk("mdc_load", mdc, 8'(nv));
        $display("test power-up done");
        hm.ask(1'h1);
        chk("remote", remote, 8'h01);
        chk("beat_osc", beat, 8'h00);
        pr(0);
        pr(1);
        chk("mode_in_remote", mode, 8'(fpmc_pkg::md_tune));
        pr(2);
        chk("remote_left", remote, 8'h00);
        hm.lock(1'h1);
        hm.ask(1'h1);
        pr(0);
        pr(2);
        chk("remote_locked", remote, 8'h01);
        hm.lock(1'h0);
        hm.ask(1'h0);
        $display("test remote done");
        rst;
        pr(0);
        pr(1);
        chk("mode_bus", mode, 8'(fpmc_pkg::md_bus));
        chk("bus_lamp", blamp, 8'h01);
        a = $urandom % 31;
        ent(a);
        chk("own_commit", own, 8'(a));
        ent(31);
        chk("own_kept", own, 8'(a));
        chk("entry_errs", 8'(n_err), 8'h01);
        pr(6, 7);
        pr(2);
        chk("own_cleared", own, 8'(a));
        pr(9);
        pr(8);
        chk("remote_item_off", ren, 8'h00);
        b = $urandom % 31;
        ent(b);
        chk("mdc_commit", mdc, 8'(b));
        chk("nv_writes", 8'(n_nv), 8'h01);
        chk("nv_data", last_nv, 8'(b));
        pr(11);
        b = (b < 30) ? b + 1 : 30;
        chk("mdc_knob", mdc, 8'(b));
        pr(8);
        chk("mdc_release", 8'(n_rel), 8'h01);
        chk("ctrl_hold", hold, 8'h01);
        pr(11);
        chk("mdc_frozen", mdc, 8'(b));
        $display("test bus options done");
        pr(0);
        pr(3);
        for (int i = 3; i >= 0; i--) begin
            pr(i == 0 ? 9 : (i == 3 ? 10 : 7));
            chk("bright", bright, 8'(i == 3 ? 3 : (i == 0 ? 2 : i)));
        end
        $display("test brightness done");
        pr(0);
        pr(2);
        chk("mode_reset", mode, 8'(fpmc_pkg::md_reset));
        pr(9);
        pr(1);
        chk("mem_rst_temp", 8'(n_mrt), 8'h01);
        chk("mode_after_fire", mode, 8'(fpmc_pkg::md_tune));
        $display("test reset choice done");
        report_and_stop;
    end
endmodule
